// ---- design/frwp_device.sv ----
// Purpose: Flash command logic for latch and register write instructions
// Assumes: Link signals asynchronous to pclk; sck mode 0
// Notes:   Register update time is a parameter
`timescale 1ns/1ps
module frwp_device
  import frwp_pkg::*;
#(
  parameter int UPDATE_CYCLES = UPDATE_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  frwp_link_if.device     link,
  input  wire logic [7:0] cfg1_nv_init,
  input  wire logic       qpi_enable,
  input  wire logic       fail_program,
  input  wire logic       fail_erase,
  output logic      [7:0] status1_v,
  output logic      [7:0] status1_nv,
  output logic      [7:0] config1_v,
  output logic            busy
);
  // ********************************************
  // Synchronisers
  // ********************************************
  logic [1:0] sck_s_ff, cs_s_ff, wp_s_ff;
  logic [3:0] io_a_ff, io_b_ff;
  logic       sck_d_ff, cs_d_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s_ff <= 2'b00;
      cs_s_ff  <= 2'b11;
      wp_s_ff  <= 2'b11;
      io_a_ff  <= 4'h0;
      io_b_ff  <= 4'h0;
      sck_d_ff <= 1'b0;
      cs_d_ff  <= 1'b1;
    end else begin
      sck_s_ff <= {sck_s_ff[0], link.sck};
      cs_s_ff  <= {cs_s_ff[0], link.cs_n};
      wp_s_ff  <= {wp_s_ff[0], link.wp_n};
      io_a_ff  <= link.io;
      io_b_ff  <= io_a_ff;
      sck_d_ff <= sck_s_ff[1];
      cs_d_ff  <= cs_s_ff[1];
    end
  end
  logic sck_rise, sck_fall, cs_rise, cs_low, wp_high;
  assign sck_rise = sck_s_ff[1] & ~sck_d_ff;
  assign sck_fall = ~sck_s_ff[1] & sck_d_ff;
  assign cs_low   = ~cs_s_ff[1];
  assign cs_rise  = cs_s_ff[1] & ~cs_d_ff;
  assign wp_high  = wp_s_ff[1];

  // ********************************************
  // Registers
  // ********************************************
  logic [7:0] status1_volatile_ff, status1_nonvolatile_ff, config1_volatile_ff, config1_nonvolatile_ff;
  logic       quad_ff;
  logic [5:0] bitcnt_ff;
  logic [23:0] shift_ff;
  logic [7:0] pend_sr_ff, pend_cr_ff;
  logic       pend_cr_en_ff;
  logic [$clog2(UPDATE_CYCLES+2)-1:0] tmr_ff;
  logic       phase_ff;   // 0 erase, 1 program
  logic       cfg_ld_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cfg_ld_ff <= 1'b0;
    else
      cfg_ld_ff <= 1'b1;
  end

  // Quad decode latched at frame start so mid-frame changes are harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      quad_ff <= 1'b0;
    else if (cs_s_ff[1] && !cs_low)
      quad_ff <= qpi_enable;
  end

  // Lane shift: one bit on io0, or four on io[3:0]
  logic [5:0] nxt_bitcnt;
  logic [23:0] nxt_shift;
  always_comb begin
    nxt_bitcnt = bitcnt_ff;
    nxt_shift  = shift_ff;
    if (sck_rise) begin
      if (quad_ff) begin
        nxt_shift  = {shift_ff[19:0], io_b_ff};
        nxt_bitcnt = bitcnt_ff + 6'd4;
      end else begin
        nxt_shift  = {shift_ff[22:0], io_b_ff[0]};
        nxt_bitcnt = bitcnt_ff + 6'd1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitcnt_ff <= 6'd0;
      shift_ff  <= 24'h0000_00;
    end else if (!cs_low) begin
      bitcnt_ff <= 6'd0;
      shift_ff  <= 24'h0000_00;
    end else if (bitcnt_ff < 6'd32) begin
      bitcnt_ff <= nxt_bitcnt;
      shift_ff  <= nxt_shift;
    end
  end

  // ********************************************
  // Command decode at select rise
  // ********************************************
  logic [7:0] op_now;
  logic       write_enable_latch, write_in_progress, hw_protect, reg_wr_ok;
  logic       do_write_enable_cmd, do_write_disable_cmd, do_wrr8, do_wrr16;
  assign write_enable_latch = status1_volatile_ff[SR_WEL];
  assign write_in_progress = status1_volatile_ff[SR_WIP];
  assign op_now = (bitcnt_ff == 6'd8)  ? shift_ff[7:0] :
                  (bitcnt_ff == 6'd16) ? shift_ff[15:8] : shift_ff[23:16];
  // Pin protection: disable bit set, pin low, and not in quad mode
  assign hw_protect = status1_volatile_ff[SR_STATUS_WRITE_DISABLE] && !wp_high && !config1_volatile_ff[CR1_QUAD];
  assign reg_wr_ok = write_enable_latch && !write_in_progress && !hw_protect;
  assign do_write_enable_cmd  = cs_rise && bitcnt_ff == 6'd8 && op_now == OP_WRITE_ENABLE;
  assign do_write_disable_cmd  = cs_rise && bitcnt_ff == 6'd8 && op_now == OP_WRITE_DISABLE
                    && !write_in_progress;
  assign do_wrr8  = cs_rise && bitcnt_ff == 6'd16 && op_now == OP_REGISTER_WRITE
                    && reg_wr_ok;
  assign do_wrr16 = cs_rise && bitcnt_ff == 6'd24 && op_now == OP_REGISTER_WRITE
                    && reg_wr_ok;

  // ********************************************
  // Self-timed update: erase phase then program phase
  // ********************************************
  logic upd_done;
  assign upd_done = write_in_progress && phase_ff && tmr_ff == '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_ff        <= '0;
      phase_ff      <= 1'b0;
      pend_sr_ff    <= 8'h00;
      pend_cr_ff    <= 8'h00;
      pend_cr_en_ff <= 1'b0;
    end else if (do_wrr8 || do_wrr16) begin
      tmr_ff        <= ($clog2(UPDATE_CYCLES+2))'(UPDATE_CYCLES / 2);
      phase_ff      <= 1'b0;
      pend_sr_ff    <= (do_wrr8 ? shift_ff[7:0] : shift_ff[15:8]) & ~SR_RESERVED_MASK;
      pend_cr_ff    <= shift_ff[7:0] & CR1_WRITE_MASK;
      pend_cr_en_ff <= do_wrr16;
    end else if (write_in_progress) begin
      if (tmr_ff != '0)
        tmr_ff <= tmr_ff - 1'b1;
      else if (!phase_ff) begin
        phase_ff <= 1'b1;
        tmr_ff   <= ($clog2(UPDATE_CYCLES+2))'(UPDATE_CYCLES - UPDATE_CYCLES / 2);
      end
    end
  end

  // Status 1 volatile: latch, busy, errors, protect bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      status1_volatile_ff <= SR1_RESET;
    else if (!cfg_ld_ff)
      status1_volatile_ff <= SR1_RESET;
    else if (do_wrr8 || do_wrr16) begin
      status1_volatile_ff[SR_WIP] <= 1'b1;
    end else if (upd_done) begin
      status1_volatile_ff[SR_WIP] <= 1'b0;
      status1_volatile_ff[SR_WEL] <= 1'b0;
      status1_volatile_ff[SR_PERR] <= status1_volatile_ff[SR_PERR] | fail_program;
      status1_volatile_ff[SR_EERR] <= status1_volatile_ff[SR_EERR] | fail_erase;
      if (!(fail_program || fail_erase)) begin
        status1_volatile_ff[SR_STATUS_WRITE_DISABLE] <= pend_sr_ff[SR_STATUS_WRITE_DISABLE];
        if (config1_nonvolatile_ff[CR1_BPSEL])
          status1_volatile_ff[SR_BP_HI:SR_BP_LO] <= pend_sr_ff[SR_BP_HI:SR_BP_LO];
      end
    end else if (do_write_enable_cmd)
      status1_volatile_ff[SR_WEL] <= 1'b1;
    else if (do_write_disable_cmd)
      status1_volatile_ff[SR_WEL] <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      status1_nonvolatile_ff <= SR1_RESET;
    else if (upd_done && !(fail_program || fail_erase)) begin
      status1_nonvolatile_ff[SR_STATUS_WRITE_DISABLE] <= pend_sr_ff[SR_STATUS_WRITE_DISABLE];
      if (!config1_nonvolatile_ff[CR1_BPSEL])
        status1_nonvolatile_ff[SR_BP_HI:SR_BP_LO] <= pend_sr_ff[SR_BP_HI:SR_BP_LO];
    end
  end

  // Strap-like nonvolatile config captured after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config1_volatile_ff  <= CR1_RESET;
      config1_nonvolatile_ff <= CR1_RESET;
    end else if (!cfg_ld_ff) begin
      config1_volatile_ff  <= cfg1_nv_init;
      config1_nonvolatile_ff <= cfg1_nv_init;
    end else if (upd_done && pend_cr_en_ff && !(fail_program || fail_erase)) begin
      config1_volatile_ff  <= pend_cr_ff;
      config1_nonvolatile_ff <= pend_cr_ff;
    end
  end

  // ********************************************
  // Status read output, served even while busy
  // ********************************************
  logic [7:0] rd_shift_ff;
  logic       rd_active_ff;
  logic [3:0] dout_ff, doe_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_shift_ff  <= 8'h00;
      rd_active_ff <= 1'b0;
      dout_ff      <= 4'h0;
      doe_ff       <= 4'h0;
    end else if (!cs_low) begin
      rd_active_ff <= 1'b0;
      doe_ff       <= 4'h0;
    end else if (sck_fall) begin
      if (!rd_active_ff && bitcnt_ff == 6'd8 && shift_ff[7:0] == OP_READ_STATUS1) begin
        rd_active_ff <= 1'b1;
        rd_shift_ff  <= quad_ff ? {status1_volatile_ff[3:0], 4'h0} : {status1_volatile_ff[6:0], 1'b0};
        dout_ff      <= quad_ff ? status1_volatile_ff[7:4] : {2'b00, status1_volatile_ff[7], 1'b0};
        doe_ff       <= quad_ff ? 4'hF : 4'h2;
      end else if (rd_active_ff) begin
        rd_shift_ff <= quad_ff ? {rd_shift_ff[3:0], 4'h0} : {rd_shift_ff[6:0], 1'b0};
        dout_ff     <= quad_ff ? rd_shift_ff[7:4] : {2'b00, rd_shift_ff[7], 1'b0};
      end
    end
  end
  assign link.io_dev_out = dout_ff;
  assign link.io_dev_oe  = doe_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status1_v  <= SR1_RESET;
      status1_nv <= SR1_RESET;
      config1_v  <= CR1_RESET;
      busy       <= 1'b0;
    end else begin
      status1_v  <= status1_volatile_ff;
      status1_nv <= status1_nonvolatile_ff;
      config1_v  <= config1_volatile_ff;
      busy       <= status1_volatile_ff[SR_WIP];
    end
  end
endmodule : frwp_device

// ---- design/frwp_pkg.sv ----
// Purpose: Shared constants for the flash register write-protect link
// Assumes: Mode 0 serial link, MSB first, opcode then data bytes
// Notes:   Both ends import this package
package frwp_pkg;
  localparam logic [7:0] OP_REGISTER_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] OP_READ_STATUS1   = 8'h05;
  localparam int SR_WIP  = 0;
  localparam int SR_WEL  = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_BP_HI = 4;
  localparam int SR_EERR = 5;
  localparam int SR_PERR = 6;
  localparam int SR_STATUS_WRITE_DISABLE = 7;
  localparam int CR1_QUAD  = 1;
  localparam int CR1_BPSEL = 3;
  localparam int CR2_QPI   = 6;
  localparam logic [7:0] SR_RESERVED_MASK = 8'h00;
  localparam logic [7:0] CR1_WRITE_MASK   = 8'hFF;
  localparam logic [7:0] SR1_RESET  = 8'h00;
  localparam logic [7:0] CR1_RESET  = 8'h00;
  localparam int CLK_MHZ      = 125;
  localparam int UPDATE_NS    = 2000;
  localparam int UPDATE_CYC   = (UPDATE_NS * CLK_MHZ) / 1000;
  localparam int SCK_HALF_CYC = 4;
  typedef enum logic [1:0] {
    FRWP_HC_IDLE = 2'b00,
    FRWP_HC_LOW  = 2'b01,
    FRWP_HC_HIGH = 2'b10,
    FRWP_HC_END  = 2'b11
  } frwp_hstate_t;
endpackage : frwp_pkg

// ---- design/frwp_link_if.sv ----
// Purpose: Serial link between host controller and flash command logic
// Assumes: Tristate lines resolved here from enables
// Notes:   Pull-ups model idle high lines
`timescale 1ns/1ps
interface frwp_link_if;
  logic       sck;
  logic       cs_n;
  logic [3:0] io_host_out;
  logic [3:0] io_host_oe;
  logic [3:0] io_dev_out;
  logic [3:0] io_dev_oe;
  logic [3:0] io;
  logic       wp_n;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (io_host_oe[i])
        io[i] = io_host_out[i];
      else if (io_dev_oe[i])
        io[i] = io_dev_out[i];
      else
        io[i] = 1'b1;
    end
  end
  modport device (input sck, input cs_n, input io, input wp_n,
                  output io_dev_out, output io_dev_oe);
  modport host (output sck, output cs_n, output io_host_out, output io_host_oe,
                output wp_n, input io);
endinterface : frwp_link_if

// ---- design/frwp_host.sv ----
// Purpose: Host controller issuing latch and register write frames over APB
// Assumes: Frames of 8, 16 or 24 bits; status read returns one byte
// Notes:   sck derived by divider from pclk
`timescale 1ns/1ps
module frwp_host
  import frwp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  frwp_link_if.host        link
);
  localparam logic [11:0] A_CMD  = 12'h000; // [7:0] op [15:8] d0 [23:16] d1 [25:24] nbytes
  localparam logic [11:0] A_CTRL = 12'h004; // [0] quad lanes, [1] wp pin level
  localparam logic [11:0] A_STAT = 12'h008; // [0] busy, [15:8] last read byte
  // ********************************************
  // APB slave
  // ********************************************
  logic [31:0] cmd_ff;
  logic [1:0]  ctrl_ff;
  logic        go_ff, busy_ff;
  logic [7:0]  rd_ff;
  logic        acc;
  assign acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff  <= 32'h0000_0000;
      ctrl_ff <= 2'b10;
      go_ff   <= 1'b0;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      go_ff   <= 1'b0;
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !(paddr == A_CMD || paddr == A_CTRL || paddr == A_STAT);
        unique case (paddr)
          A_CMD:   prdata <= cmd_ff;
          A_CTRL:  prdata <= {30'h0, ctrl_ff};
          A_STAT:  prdata <= {16'h0, rd_ff, 7'h0, busy_ff};
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (acc && pready && pwrite) begin
        if (paddr == A_CMD && !busy_ff) begin
          cmd_ff <= pwdata;
          go_ff  <= 1'b1;
        end
        if (paddr == A_CTRL)
          ctrl_ff <= pwdata[1:0];
      end
    end
  end
  // ********************************************
  // Link engine
  // ********************************************
  frwp_hstate_t st_ff;
  logic [2:0]  div_ff;
  logic [5:0]  nbits_ff, sent_ff;
  logic [23:0] sh_ff;
  logic [3:0]  io_s1_ff, io_s2_ff;
  logic        sck_ff, cs_ff;
  logic [3:0]  out_ff, oe_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_s1_ff <= 4'h0;
      io_s2_ff <= 4'h0;
    end else begin
      io_s1_ff <= link.io;
      io_s2_ff <= io_s1_ff;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= FRWP_HC_IDLE;
      div_ff <= 3'd0;
      nbits_ff <= 6'd0;
      sent_ff <= 6'd0;
      sh_ff <= 24'h0000_00;
      sck_ff <= 1'b0;
      cs_ff <= 1'b1;
      out_ff <= 4'h0;
      oe_ff <= 4'h0;
      busy_ff <= 1'b0;
      rd_ff <= 8'h00;
    end else begin
      unique case (st_ff)
        FRWP_HC_IDLE: if (go_ff) begin
          busy_ff  <= 1'b1;
          cs_ff    <= 1'b0;
          nbits_ff <= {3'(cmd_ff[25:24]) + 3'd1, 3'b000};
          sh_ff    <= {cmd_ff[7:0], cmd_ff[15:8], cmd_ff[23:16]};
          sent_ff  <= 6'd0;
          div_ff   <= 3'd0;
          st_ff    <= FRWP_HC_LOW;
          oe_ff    <= ctrl_ff[0] ? 4'hF : 4'h1;
          out_ff   <= ctrl_ff[0] ? cmd_ff[7:4] : {3'b000, cmd_ff[7]};
        end
        FRWP_HC_LOW: if (div_ff == 3'(SCK_HALF_CYC - 1)) begin
          div_ff <= 3'd0;
          sck_ff <= 1'b1;
          st_ff  <= FRWP_HC_HIGH;
        end else
          div_ff <= div_ff + 3'd1;
        FRWP_HC_HIGH: if (div_ff == 3'(SCK_HALF_CYC - 1)) begin
          div_ff <= 3'd0;
          sck_ff <= 1'b0;
          rd_ff  <= ctrl_ff[0] ? {rd_ff[3:0], io_s2_ff} : {rd_ff[6:0], io_s2_ff[1]};
          sent_ff <= sent_ff + (ctrl_ff[0] ? 6'd4 : 6'd1);
          sh_ff  <= ctrl_ff[0] ? {sh_ff[19:0], 4'h0} : {sh_ff[22:0], 1'b0};
          out_ff <= ctrl_ff[0] ? sh_ff[19:16] : {3'b000, sh_ff[22]};
          // Let go of the lines once a status read opcode is out, so quad data can return
          if (cmd_ff[7:0] == OP_READ_STATUS1 && sent_ff + (ctrl_ff[0] ? 6'd4 : 6'd1) == 6'd8)
            oe_ff <= 4'h0;
          // Raise select one cycle after the last counted bit, from the end state
          if (sent_ff + (ctrl_ff[0] ? 6'd4 : 6'd1) >= nbits_ff)
            st_ff <= FRWP_HC_END;
          else
            st_ff <= FRWP_HC_LOW;
        end else
          div_ff <= div_ff + 3'd1;
        FRWP_HC_END: begin
          cs_ff   <= 1'b1;
          oe_ff   <= 4'h0;
          busy_ff <= 1'b0;
          st_ff   <= FRWP_HC_IDLE;
        end
        default: st_ff <= FRWP_HC_IDLE;
      endcase
    end
  end
  assign link.sck         = sck_ff;
  assign link.cs_n        = cs_ff;
  assign link.io_host_out = out_ff;
  assign link.io_host_oe  = oe_ff;
  assign link.wp_n        = ctrl_ff[1];
endmodule : frwp_host

// ---- testbench/frwp_link_monitor.sv ----
// Purpose: Assertions on the link and the self-timed update flags
// Assumes: busy and status1_v are taken from the device end
// Notes:   Spans sized for an update of a few hundred cycles
`timescale 1ns/1ps
module frwp_link_monitor
  import frwp_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       cs_n,
  input wire logic       busy,
  input wire logic [7:0] status1_v
);
  // ****************
  // Update sequencing
  // ****************
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_start;
    $rose(busy);
  endsequence
  sequence s_done;
    $fell(busy);
  endsequence
  property p_perr_set; $rose(status1_v[SR_PERR]) |-> $fell(busy); endproperty
  a_perr_set: assert property (p_perr_set) else $error("program error off completion");
  property p_start_sel; s_start |-> cs_n; endproperty
  a_start_sel: assert property (p_start_sel) else $error("update began inside a frame");
  property p_start_wel; s_start |-> $past(status1_v[SR_WEL]); endproperty
  a_start_wel: assert property (p_start_wel) else $error("update began without latch");
  property p_min_upd; s_start |-> busy[*8]; endproperty
  a_min_upd: assert property (p_min_upd) else $error("update too short");
  property p_max_upd; s_start |-> ##[1:600] !busy; endproperty
  a_max_upd: assert property (p_max_upd) else $error("update never ended");
  property p_wel_done; s_done |-> ##[0:2] !status1_v[SR_WEL]; endproperty
  a_wel_done: assert property (p_wel_done) else $error("latch kept after update");
  property p_wel_kept; busy && status1_v[SR_WEL] |=> status1_v[SR_WEL] || !busy; endproperty
  a_wel_kept: assert property (p_wel_kept) else $error("latch dropped during update");
  property p_wel_set; $rose(status1_v[SR_WEL]) |-> cs_n && !busy; endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch set at a wrong moment");
  property p_status_write_disable_chg; $changed(status1_v[SR_STATUS_WRITE_DISABLE]) |-> busy || $past(busy); endproperty
  a_status_write_disable_chg: assert property (p_status_write_disable_chg) else $error("disable bit moved off update");
  property p_err_set;
    $rose(status1_v[SR_EERR]) |-> busy || $past(busy) || $past(busy, 2);
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag outside update");
endmodule : frwp_link_monitor

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench joining host and device ends
// Assumes: Update shortened to 200 cycles; quad lanes with quad decode, except one directed step that sends quad lanes without it
// Notes:   Random steps mixed with directed protection cases
`timescale 1ns/1ps
module tb
  import frwp_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, r;
  logic [7:0]  cfg1_nv_init, status1_v, status1_nv, config1_v, e_v, e_c, s0, sh1, shq, d0, d1;
  logic [2:0]  e_bpnv;
  logic        qpi_enable, fail_program, fail_erase, busy, c_known, nvsel, quad, wp, sck_q, cs_q;
  integer      err_total, comparisons, seed, nbit;
  frwp_link_if link ();
  frwp_device #(.UPDATE_CYCLES(200)) frwp_device_i (.pclk(pclk), .presetn(presetn), .link(link),
    .cfg1_nv_init(cfg1_nv_init), .qpi_enable(qpi_enable), .fail_program(fail_program),
    .fail_erase(fail_erase), .status1_v(status1_v), .status1_nv(status1_nv),
    .config1_v(config1_v), .busy(busy));
  frwp_host frwp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  frwp_link_monitor frwp_link_monitor_i (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
    .busy(busy), .status1_v(status1_v));
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  // ****************
  // Wire watcher: bits on the lines, MSB first
  // ****************
  always @(posedge pclk) begin
    sck_q <= link.sck;
    cs_q <= link.cs_n;
    if (cs_q && !link.cs_n) begin
      nbit <= 0;
    end else if (!link.cs_n && link.sck && !sck_q) begin
      nbit <= nbit + 1;
      sh1 <= {sh1[6:0], link.io[0]};
      shq <= {shq[3:0], link.io};
    end
  end
  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    close_out();
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic frame(input logic [7:0] op, c0, c1, input logic [1:0] nb);
    apb(1'h1, 12'h000, {6'h00, nb, c1, c0, op});
    do begin
      apb(1'h0, 12'h008, 32'h0000_0000);
    end while (q[0] !== 1'h0);
    s0 = q[15:8];
  endtask : frame
  task automatic poll();
    while (s0[SR_WIP] !== 1'h0) begin
      frame(OP_READ_STATUS1, 8'h00, 8'h00, 2'h1);
    end
  endtask : poll
  task automatic ctrl(input logic qd, input logic w);
    apb(1'h1, 12'h004, {30'h0, w, qd});
    quad = qd;
    wp = w;
    qpi_enable <= qd;
  endtask : ctrl
  task automatic check_regs();
    chk("status1_v", status1_v, e_v);
    chk("protect nv", 8'(status1_nv[4:2]), 8'(e_bpnv));
    if (c_known) chk("config1_v", config1_v, e_c);
  endtask : check_regs
  task automatic cmd(input logic [7:0] op, c0, c1, input logic [1:0] nb);
    logic ok;
    logic [7:0] last;
    ok = op == OP_REGISTER_WRITE && nb != 2'h0 && e_v[SR_WEL]
         && (!e_v[SR_STATUS_WRITE_DISABLE] || wp || e_c[CR1_QUAD]);
    frame(op, c0, c1, nb);
    last = nb == 2'h0 ? op : (nb == 2'h1 ? c0 : c1);
    chk("bit count", 8'(nbit), quad ? 8'(2 * nb + 2) : 8'(8 * nb + 8));
    chk("last byte", quad ? shq : sh1, last);
    if (nb == 2'h0 && op == OP_WRITE_ENABLE) e_v[SR_WEL] = 1'h1;
    if (nb == 2'h0 && op == OP_WRITE_DISABLE) e_v[SR_WEL] = 1'h0;
    frame(OP_READ_STATUS1, 8'h00, 8'h00, 2'h1);
    if (ok) begin
      chk("wip and latch", s0 & 8'h03, 8'h03);
      poll();
      e_v[SR_WEL] = 1'h0;
      if (fail_erase | fail_program) begin
        e_v[6:5] = e_v[6:5] | {fail_program, fail_erase};
      end else begin
        e_v[SR_STATUS_WRITE_DISABLE] = c0[SR_STATUS_WRITE_DISABLE];
        if (nvsel) e_v[4:2] = c0[4:2];
        else e_bpnv = c0[4:2];
        if (nb == 2'h2) e_c = c1;
        c_known = c_known | (nb == 2'h2);
      end
    end
    chk("status read", s0, e_v);
    check_regs();
  endtask : cmd
  task automatic do_reset(input logic sel);
    presetn <= 1'h0;
    cfg1_nv_init <= {4'h0, sel, 3'h0};
    qpi_enable <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    {nvsel, e_v, e_bpnv, e_c, c_known, quad, wp} = {sel, 8'h00, 3'h0, 4'h0, sel, 3'h0, 3'h5};
    repeat (2) @(posedge pclk);
    chk("reset status1_v", status1_v, 8'h00);
    chk("reset status1_nv", status1_nv, 8'h00);
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk("ctrl reset", q[7:0], 8'h02);
  endtask : do_reset
  initial begin
    {err_total, comparisons, nbit, seed} = {32'h0, 32'h0, 32'h0, 32'h2ee1};
    {presetn, psel, penable, pwrite, paddr, pwdata, cfg1_nv_init} = '0;
    {qpi_enable, fail_program, fail_erase} = 3'h0;
    do_reset(1'h0);
    apb(1'h0, 12'h00C, 32'h0000_0000);
    chk("unmapped", 8'(err_q), 8'h01);
    cmd(OP_REGISTER_WRITE, 8'h9C, 8'h00, 2'h1);
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h1);
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h0);
    cmd(OP_REGISTER_WRITE, 8'h00, 8'h00, 2'h0);
    cmd(OP_WRITE_DISABLE, 8'h00, 8'h00, 2'h0);
    $display("test latch done");
    ctrl(1'h0, 1'h0);
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h0);
    cmd(OP_REGISTER_WRITE, 8'h9C, 8'h00, 2'h2);
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h0);
    cmd(OP_REGISTER_WRITE, 8'h00, 8'h00, 2'h1);
    ctrl(1'h0, 1'h1);
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h0);
    cmd(OP_REGISTER_WRITE, 8'h88, 8'h02, 2'h2);
    ctrl(1'h0, 1'h0);
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h0);
    cmd(OP_REGISTER_WRITE, 8'h84, 8'h00, 2'h2);
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h0);
    cmd(OP_REGISTER_WRITE, 8'h00, 8'h00, 2'h1);
    ctrl(1'h0, 1'h1);
    cmd(OP_REGISTER_WRITE, 8'h00, 8'h00, 2'h1);
    $display("test protection done");
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h0);
    frame(OP_REGISTER_WRITE, 8'h08, 8'h00, 2'h1);
    frame(OP_WRITE_DISABLE, 8'h00, 8'h00, 2'h0);
    frame(OP_READ_STATUS1, 8'h00, 8'h00, 2'h1);
    chk("latch kept busy", s0 & 8'h03, 8'h03);
    poll();
    {e_v[SR_WEL], e_v[SR_STATUS_WRITE_DISABLE], e_bpnv} = {2'h0, 3'h2};
    check_regs();
    apb(1'h1, 12'h004, 32'h0000_0003);
    frame(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h0);
    ctrl(1'h0, 1'h1);
    frame(OP_READ_STATUS1, 8'h00, 8'h00, 2'h1);
    chk("quad gate", s0, e_v);
    ctrl(1'h1, 1'h1);
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h0);
    cmd(OP_REGISTER_WRITE, 8'h10, 8'h00, 2'h2);
    ctrl(1'h0, 1'h1);
    for (int i = 1; i < 3; i++) begin
      {fail_program, fail_erase} <= 2'(i);
      cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, 2'h0);
      cmd(OP_REGISTER_WRITE, 8'h1C, 8'h00, 2'h1);
    end
    {fail_program, fail_erase} <= 2'h0;
    $display("test sequencing done");
    for (int b = 0; b < 2; b++) begin
      do_reset(1'(b));
      repeat (18) begin
        r = $random(seed);
        d0 = r[31:24] & 8'h9C;
        d1 = {r[23:20], nvsel, r[18:16]};
        ctrl(r[12], r[9]);
        case (r[2:0])
          3'h0, 3'h6: cmd(OP_WRITE_ENABLE, d0, d1, 2'h0);
          3'h1: cmd(OP_WRITE_DISABLE, d0, d1, 2'h0);
          3'h4: cmd(OP_WRITE_ENABLE, d0, d1, 2'h1);
          3'h5: cmd(OP_REGISTER_WRITE, d0, d1, 2'h0);
          default: cmd(OP_REGISTER_WRITE, d0, d1, r[3] ? 2'h2 : 2'h1);
        endcase
      end
      $display("test random batch done");
    end
    close_out();
  end
endmodule : tb
